// ===== bbsram_pkg.sv
// Purpose: Constants for the host-side controller of a battery-backed 8K x 8 static memory
// Assumes: 125 MHz mclk (8 ns period)
// Notes: Times in ns, recovery in ms; cycle counts derived from them
package bbsram_pkg;
   // ****************************************
   // Geometry
   // ****************************************
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   localparam int MEM_DEPTH = 8192;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 8;
   localparam int ADDR_ACCESS_NS = 70;
   localparam int SEL_ACCESS_NS = 70;
   localparam int OUT_ACCESS_NS = 35;
   localparam int STROBE_LOW_NS = 50;
   localparam int DATA_SETUP_NS = 30;
   localparam int DATA_HOLD_NS = 5;
   localparam int RELEASE_GAP_NS = 0;
   localparam int HIGHZ_NS = 25;
   localparam int REC_MAX_MS = 200;
   // Least times round up, at least one cycle
   localparam int READ_CYC = (ADDR_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
   localparam int WR_LOW_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETUP_CYC = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CYC = (DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GAP_CYC = (RELEASE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
   localparam int HIGHZ_CYC = (HIGHZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REC_CYC_DEF = REC_MAX_MS * 125000;
   localparam logic [3:0] CNT_ZERO = 4'h0;
endpackage

// ===== bbsram_sync.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: First stage read only by second stage
// Notes: Width is a parameter
`timescale 1ns/1ps
module bbsram_sync #(parameter int W = 1)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_q;
   // Two stages, cleared by reset
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         meta_q <= '0;
         dout <= '0;
      end
      else
      begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule

// ===== bbsram_host.sv
// Purpose: Host bus master for a battery-backed 8K x 8 asynchronous memory
// Assumes: One request at a time over a valid/ready port
// Notes: Waits out power-up recovery after reset before any access
`timescale 1ns/1ps
module bbsram_host
   import bbsram_pkg::*;
#(
   parameter int REC_CYC = REC_CYC_DEF
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic [bbsram_pkg::ADDR_W-1:0] req_addr,
   input wire logic [bbsram_pkg::DATA_W-1:0] req_wdata,
   output logic rsp_valid,
   output logic [bbsram_pkg::DATA_W-1:0] rsp_rdata,
   output logic [bbsram_pkg::ADDR_W-1:0] addr_lines,
   output logic cs_n,
   output logic out_drv_n,
   output logic store_strobe_n,
   input wire logic [bbsram_pkg::DATA_W-1:0] data_pins_i,
   output logic [bbsram_pkg::DATA_W-1:0] data_pins_o,
   output logic data_pins_oe
);
   import bbsram_pkg::*;

   typedef enum {ST_RECOVER, ST_IDLE, ST_READ, ST_WSETUP, ST_WLOW, ST_WHOLD, ST_GAP} bbsram_st_t;

   // ****************************************
   // State
   // ****************************************
   bbsram_st_t st_q, st_d;
   logic [3:0] cnt_q, cnt_d;
   logic [31:0] rec_q;
   logic [DATA_W-1:0] din_s;
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] wdata_q;
   logic [DATA_W-1:0] rdata_q;
   logic rsp_q;
   logic cs_n_q, oe_n_q, we_n_q, drv_q;

   // Data pins come from another domain, so synchronise first
   bbsram_sync #(.W(DATA_W)) u_sync
   (
      .mclk(mclk),
      .rst(rst),
      .din(data_pins_i),
      .dout(din_s)
   );

   // ****************************************
   // Decode
   // ****************************************
   wire cnt_done = (cnt_q == CNT_ZERO);
   wire rec_done = (rec_q == 32'h0);
   wire take = (st_q == ST_IDLE) && req_valid;
   wire read_capture = (st_q == ST_READ) && cnt_done;

   // Ready only while idle, after recovery has run out
   assign req_ready = (st_q == ST_IDLE);
   assign rsp_valid = rsp_q;
   assign rsp_rdata = rdata_q;
   assign addr_lines = addr_q;
   assign cs_n = cs_n_q;
   assign out_drv_n = oe_n_q;
   assign store_strobe_n = we_n_q;
   assign data_pins_o = wdata_q;
   assign data_pins_oe = drv_q;

   // Sequencer; cycle counts include two synchroniser stages on reads
   always_comb
   begin
      st_d = st_q;
      cnt_d = cnt_done ? CNT_ZERO : cnt_q - 4'h1;
      unique case (st_q)
         ST_RECOVER: if (rec_done) st_d = ST_IDLE;
         ST_IDLE:
         begin
            if (take && req_write)
            begin
               st_d = ST_WSETUP;
               cnt_d = 4'(SETUP_CYC - 1);
            end
            else if (take)
            begin
               st_d = ST_READ;
               cnt_d = 4'(READ_CYC + 1);
            end
         end
         ST_READ: if (cnt_done)
         begin
            st_d = ST_GAP;
            cnt_d = 4'(GAP_CYC - 1);
         end
         ST_WSETUP: if (cnt_done)
         begin
            st_d = ST_WLOW;
            cnt_d = 4'(WR_LOW_CYC - 1);
         end
         ST_WLOW: if (cnt_done)
         begin
            st_d = ST_WHOLD;
            cnt_d = 4'(HOLD_CYC - 1);
         end
         ST_WHOLD: if (cnt_done)
         begin
            st_d = ST_GAP;
            cnt_d = 4'(GAP_CYC - 1);
         end
         ST_GAP: if (cnt_done) st_d = ST_IDLE;
      endcase
   end

   // ****************************************
   // Pin decode
   // ****************************************
   // Pins follow the next state, so they move on the same edge as the state;
   // every pin is a flop output and cannot glitch toward the memory
   wire rd_phase_d = (st_d == ST_READ);
   wire wr_phase_d = (st_d == ST_WSETUP) || (st_d == ST_WLOW) || (st_d == ST_WHOLD);
   wire cs_n_d = !(rd_phase_d || wr_phase_d);
   // Output drive stays high on writes so both sides never fight over the data pins
   wire oe_n_d = !rd_phase_d;
   // Strobe only inside the select window; address is frozen from accept
   wire we_n_d = !(st_d == ST_WLOW);
   // Data drive spans the whole write select, so setup and hold come from the phases
   wire drv_d = wr_phase_d;
   // Answer pulses one cycle after a read capture or the end of the write hold
   wire wr_done = (st_q == ST_WHOLD) && cnt_done;
   wire rsp_d = read_capture || wr_done;
   // Limitation: the host cannot see the supply, so it waits the longest
   // recovery after every reset; the counter parks at zero until rearmed
   wire [31:0] rec_d = rec_done ? 32'h0 : rec_q - 32'h1;

   // ****************************************
   // Registers
   // ****************************************
   // Sequencer state; recovery starts over on every reset
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         st_q <= ST_RECOVER;
         cnt_q <= CNT_ZERO;
         rec_q <= 32'(REC_CYC);
      end
      else
      begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         rec_q <= rec_d;
      end
   end

   // Pin levels; all inactive and undriven in reset so the memory sees a deselect
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         cs_n_q <= 1'b1;
         oe_n_q <= 1'b1;
         we_n_q <= 1'b1;
         drv_q <= 1'b0;
      end
      else
      begin
         cs_n_q <= cs_n_d;
         oe_n_q <= oe_n_d;
         we_n_q <= we_n_d;
         drv_q <= drv_d;
      end
   end

   // Address and data latched at accept, held for the whole cycle
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         addr_q <= '0;
         wdata_q <= '0;
      end
      else if (take)
      begin
         addr_q <= req_addr;
         wdata_q <= req_wdata;
      end
   end

   // Read data stays put after the pulse, until the next read lands
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         rdata_q <= '0;
         rsp_q <= 1'b0;
      end
      else
      begin
         if (read_capture) rdata_q <= din_s;
         rsp_q <= rsp_d;
      end
   end
endmodule

// ===== bbsram_host_chk.sv
// Purpose: Pin timing checks for the memory host
// Assumes: One clock, reset active high
// Notes: Cycle figures follow the host walk
`timescale 1ns/1ps
module bbsram_host_chk
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire logic req_write,
   input wire logic rsp_valid,
   input wire logic [bbsram_pkg::ADDR_W-1:0] addr_lines,
   input wire logic cs_n,
   input wire logic out_drv_n,
   input wire logic store_strobe_n,
   input wire logic data_pins_oe
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   wire take = req_valid && req_ready;
   // Pin phases tied to the request taken
   property p_rd_sel; take && !req_write |=> !cs_n && !out_drv_n && store_strobe_n; endproperty
   a_rd_sel: assert property (p_rd_sel) else $error("read select wrong");
   property p_rd_rsp; take && !req_write |-> ##[13:14] rsp_valid; endproperty
   a_rd_rsp: assert property (p_rd_rsp) else $error("read answer late");
   property p_wr_rsp; take && req_write |-> ##[12:13] rsp_valid; endproperty
   a_wr_rsp: assert property (p_wr_rsp) else $error("write answer late");
   property p_wr_drv; !store_strobe_n |-> !cs_n && out_drv_n && data_pins_oe; endproperty
   a_wr_drv: assert property (p_wr_drv) else $error("write drive wrong");
   property p_addr; !cs_n && !$past(cs_n) |-> $stable(addr_lines); endproperty
   a_addr: assert property (p_addr) else $error("address moved");
   property p_low; $fell(store_strobe_n) |-> !store_strobe_n [*7]; endproperty
   a_low: assert property (p_low) else $error("strobe too short");
   property p_gap; $rose(cs_n) |=> cs_n; endproperty
   a_gap: assert property (p_gap) else $error("no release gap");
   property p_setup; $rose(store_strobe_n) |-> data_pins_oe && $past(data_pins_oe, 4); endproperty
   a_setup: assert property (p_setup) else $error("data setup or hold");
endmodule

// ===== bbsram_dev_model.sv
// Purpose: Behavioural battery-backed byte memory
// Assumes: Recovery shortened to REC_NS
// Notes: Released pins show the inverse of the last level
`timescale 1ns/1ps
module bbsram_dev_model
   import bbsram_pkg::*;
#(
   parameter real REC_NS = 100.0
)
(
   input wire logic [bbsram_pkg::ADDR_W-1:0] addr_lines,
   input wire logic cs_n,
   input wire logic out_drv_n,
   input wire logic store_strobe_n,
   input wire logic [bbsram_pkg::DATA_W-1:0] host_d,
   input wire logic host_oe,
   output logic [bbsram_pkg::DATA_W-1:0] pins
);
   logic [DATA_W-1:0] mem [MEM_DEPTH];
   logic [DATA_W-1:0] last_q = 8'h00;
   logic live = 1'b0;
   logic ok = 1'b0;
   realtime stamp = 0;
   wire wr_now = live && !cs_n && !store_strobe_n;
   wire rd_en = live && !cs_n && !out_drv_n && store_strobe_n;
   // A 1 ns poll is coarse but far finer than the 8 ns host clock
   always #1
   begin
      live = $realtime >= REC_NS;
      ok = ($realtime - stamp) >= ADDR_ACCESS_NS;
      if (host_oe || rd_en)
         last_q = pins;
   end
   always @(addr_lines or cs_n or out_drv_n) stamp = $realtime;
   always @(negedge wr_now) mem[addr_lines] = host_d;
   // Early reads see inverted data, never a lucky match
   assign pins = host_oe ? host_d : rd_en ? (ok ? mem[addr_lines] : ~mem[addr_lines]) : ~last_q;
endmodule

// ===== bbsram_tb.sv
// Purpose: Self-checking bench for the memory host
// Assumes: REC_CYC cut to 10 cycles
// Notes: Contents must survive a host reset
`timescale 1ns/1ps
module tb;
   import bbsram_pkg::*;
   localparam int REC_SIM = 10;
   logic mclk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0;
   logic [ADDR_W-1:0] req_addr = 13'h0000, addr_lines;
   logic [DATA_W-1:0] req_wdata = 8'h00, q, rsp_rdata, data_pins_i, data_pins_o;
   logic req_ready, rsp_valid, cs_n, out_drv_n, store_strobe_n, data_pins_oe;
   int err_count = 0, total_checks = 0;
   logic [ADDR_W-1:0] at [4] = '{13'h0000, 13'h1fff, 13'h1000, 13'h0001};
   logic [DATA_W-1:0] dt [4] = '{8'h5a, 8'ha5, 8'h3c, 8'h00};
   always #4 mclk = ~mclk;
   bbsram_host #(.REC_CYC(REC_SIM)) dut_u (.mclk, .rst, .req_valid, .req_ready, .req_write,
      .req_addr, .req_wdata, .rsp_valid, .rsp_rdata, .addr_lines, .cs_n, .out_drv_n,
      .store_strobe_n, .data_pins_i, .data_pins_o, .data_pins_oe);
   bbsram_dev_model dev_u (.addr_lines, .cs_n, .out_drv_n, .store_strobe_n,
      .host_d(data_pins_o), .host_oe(data_pins_oe), .pins(data_pins_i));
   task automatic complete_run();
      $display("checks=%0d mismatches=%0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One transfer; bounded waits so a stuck handshake ends the run
   task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int i;
      i = 0;
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= a;
      req_wdata <= d;
      do @(posedge mclk); while (req_ready !== 1'b1 && ++i < 300);
      req_valid <= 1'b0;
      do @(posedge mclk); while (rsp_valid !== 1'b1 && ++i < 300);
      q = rsp_rdata;
      if (i >= 300)
      begin
         err_count++;
         complete_run();
      end
   endtask
   // Ready must stay low for the whole recovery, then rise within a bound
   task automatic t_recover();
      int n;
      n = 0;
      repeat (REC_SIM)
      begin
         @(posedge mclk);
         check({7'h00, req_ready}, 8'h00);
      end
      do @(posedge mclk); while (req_ready !== 1'b1 && ++n < 300);
      check({7'h00, req_ready}, 8'h01);
      if (req_ready !== 1'b1)
         complete_run();
      $display("t_recover done");
   endtask
   // Corner addresses must stay distinct bytes
   task automatic t_readback();
      foreach (at[k])
      begin
         xfer(1'b0, at[k], 8'h00);
         check(q, dt[k]);
      end
      $display("t_readback done");
   endtask
   // Back-to-back writes with an overwrite of one byte
   task automatic t_fill();
      xfer(1'b1, at[2], 8'hc3);
      foreach (at[k])
      begin
         xfer(1'b1, at[k], dt[k]);
      end
      t_readback();
      $display("t_fill done");
   endtask
   initial
   begin
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      t_recover();
      t_fill();
      rst <= 1'b1;
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      t_recover();
      t_readback();
      complete_run();
   end
endmodule
bind bbsram_host bbsram_host_chk chk_u (.mclk, .rst, .req_valid, .req_ready, .req_write,
   .rsp_valid, .addr_lines, .cs_n, .out_drv_n, .store_strobe_n, .data_pins_oe);
